// ---- common/homseq_map.svh ----
// Notes on behaviour
// [R1] Method field picks origin method 0..4, latched at restart.
// [R2] Homing request with method 0 raises method-unspecified error instead.
// [R3] Direction setting, live: 0 forward, 1 reverse.
// [R4] Incremental encoder: origin value loaded into position on completion.
// [R5] Absolute encoder: origin value is encoder-to-machine offset.
// [R6] Absolute encoder: absolute origin value loaded into position on completion; homing here does not start while abs_encoder is high.
// [R7] Movement speed live, 1..199,999,999 units of 1,000/min, default 1,000.
// [R8] Approach speed same range; use depends on method.
// [R9] Creep speed same range; switch point depends on method.
// [R10] After creep, move final distance; stop point becomes origin.
// [R11] Negative final distance reverses direction after creep switch.
// [R12] Pressing homing limits torque to set percent and presses into stop.
// [R13] Press detect time 0..10,000 ms from press start to motor stop.
// [R14] Hold pressed for press time, then travel final distance opposite.
// [R15] Pressing homing: speed above overspeed level raises alarm.
// [R16] Request active starts homing; inactive halts it.
// [R17] Request again while halted resumes where stopped.
// [R18] Jog or mode change while halted cancels homing.
// [R19] Method 0 fixes origin at power-up position, no motion.
// [R20] Position-ready asserted when homing completes.
// [R21] Host selects mode 1 (mode input inactive) before homing.
// [R22] Method 1: decel switch active changes movement to approach speed.
// [R23] Request, jog, mode and decel inputs synchronised before use.
// [R24] Press times measured with millisecond tick from clock.
`ifndef HOMSEQ_MAP_SVH
`define HOMSEQ_MAP_SVH
`define HOMSEQ_CLK_HZ        20000000
`define HOMSEQ_MS_PER_S      1000
`define HOMSEQ_TICK_CYCLES   (`HOMSEQ_CLK_HZ / `HOMSEQ_MS_PER_S)
`define HOMSEQ_POS_LIMIT     32'sd1073741823
`define HOMSEQ_SPEED_MAX     28'd199999999
`define HOMSEQ_SPEED_DEF     28'd1000
`define HOMSEQ_OVSPD_DEF     28'd2000
`define HOMSEQ_TORQ_DEF      7'd25
`define HOMSEQ_TORQ_MAX      7'd100
`define HOMSEQ_TORQ_FULL     7'd100
`define HOMSEQ_TIME_DEF      14'd250
`define HOMSEQ_TIME_MAX      14'd10000
`define HOMSEQ_METH_NONE     3'h0
`define HOMSEQ_METH_DEC_IDX  3'h1
`define HOMSEQ_METH_DEC      3'h2
`define HOMSEQ_METH_IDX      3'h3
`define HOMSEQ_METH_PRESS    3'h4
`endif

// ---- common/homseq_pkg.sv ----
package homseq_pkg;
	typedef enum logic [3:0] {
		HS_IDLE,
		HS_MOVE,
		HS_APPROACH,
		HS_CREEP,
		HS_FINAL,
		HS_PRESS,
		HS_HOLD,
		HS_DONE
	} homseq_state_t;
	typedef logic signed [31:0] homseq_pos_t;
	typedef logic [27:0] homseq_speed_t;
endpackage : homseq_pkg

// ---- rtl/homseq_sync.sv ----
`timescale 1ns/10ps
module homseq_sync #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : homseq_sync

// ---- rtl/homseq_ms_timer.sv ----
`timescale 1ns/10ps
`include "homseq_map.svh"
module homseq_ms_timer #(
	parameter int TICK_CYCLES = `HOMSEQ_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Control
	input  wire logic        start,
	input  wire logic        run,
	input  wire logic [13:0] limit_ms,
	output logic             expired
);
	logic [15:0] cyc;
	logic [13:0] ms;
	wire         tick = (cyc == 16'(TICK_CYCLES - 1));

	// Counts whole milliseconds while run is high
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cyc <= 16'h0;
			ms  <= 14'h0;
		end else if (start) begin
			cyc <= 16'h0;
			ms  <= 14'h0;
		end else if (run) begin
			cyc <= tick ? 16'h0 : cyc + 16'h1;
			if (tick && ms != limit_ms)
				ms <= ms + 14'h1; // R24
		end
	end

	// Not masked by start: the owner restarts the count from expired
	assign expired = (ms >= limit_ms);
endmodule : homseq_ms_timer

// ---- rtl/homing_sequencer.sv ----
`timescale 1ns/10ps
`include "homseq_map.svh"
module homseq_top
	import homseq_pkg::*;
#(
	parameter int TICK_CYCLES = `HOMSEQ_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// Host discrete inputs
	input  wire logic          home_req,
	input  wire logic          jog_forward_req,
	input  wire logic          jog_reverse_req,
	input  wire logic          mode_sel_in,
	input  wire logic          decel_switch_in,
	// Drive feedback
	input  wire logic          index_pulse,
	input  wire logic          abs_encoder,
	input  wire homseq_speed_t motor_speed,
	input  wire homseq_pos_t   encoder_position,
	input  wire homseq_pos_t   travelled,
	input  wire logic          torque_at_limit,
	// Settings
	input  wire logic [2:0]    homing_method_sel,
	input  wire logic          homing_direction_sel,
	input  wire homseq_pos_t   origin_position_value,
	input  wire homseq_pos_t   abs_origin_value,
	input  wire homseq_speed_t homing_move_speed,
	input  wire homseq_speed_t homing_approach_speed,
	input  wire homseq_speed_t homing_creep_speed,
	input  wire homseq_pos_t   final_travel_distance,
	input  wire logic [6:0]    press_torque_limit,
	input  wire logic [13:0]   press_detect_time,
	input  wire logic [13:0]   press_hold_time,
	input  wire homseq_speed_t press_overspeed_level,
	// Motion command
	output logic               motion_run,
	output logic               motion_reverse,
	output homseq_speed_t      speed_cmd,
	output logic [6:0]         torque_limit_out,
	output logic               distance_start,
	output homseq_pos_t        distance_target,
	output logic               position_load,
	output homseq_pos_t        position_load_value,
	output homseq_pos_t        machine_position,
	// Status
	output logic               position_ready_out,
	output logic               homing_halted,
	output logic               method_unspecified_err,
	output logic               press_overspeed_alarm
);
	homseq_state_t state, next_state, resume_state;
	logic [2:0]    method;
	logic          method_loaded;
	logic          req_d, mode_d, halted;
	logic [4:0]    sync_bus;
	logic          s_req, s_jog_forward_req, s_jog_reverse_req, s_mode, s_dec;
	logic          timer_start, det_exp, hold_exp;

	homseq_sync #(.WIDTH(5)) u_sync (
		.clk     (clk),
		.resetn  (resetn),
		.async_in({home_req, jog_forward_req, jog_reverse_req, mode_sel_in, decel_switch_in}),
		.sync_out(sync_bus)
	); // R23
	assign {s_req, s_jog_forward_req, s_jog_reverse_req, s_mode, s_dec} = sync_bus;

	wire req_rise  = s_req && !req_d; // R16
	wire req_fall  = !s_req && req_d; // R16
	wire mode_chg  = s_mode != mode_d;
	wire cancel    = halted && (s_jog_forward_req || s_jog_reverse_req || mode_chg); // R18
	wire mode_ok   = !s_mode; // R21
	wire dist_neg  = final_travel_distance[31];
	wire pressing  = (method == `HOMSEQ_METH_PRESS);
	wire in_motion = (state != HS_IDLE) && (state != HS_DONE);
	// Distance feedback is stale until the restart pulse has been seen
	wire final_hit = !distance_start &&
		(travelled >= (dist_neg ? -final_travel_distance : final_travel_distance));

	function automatic homseq_state_t first_state(input logic [2:0] m);
		case (m)
			`HOMSEQ_METH_DEC_IDX: first_state = HS_MOVE;
			`HOMSEQ_METH_DEC:     first_state = HS_APPROACH;
			`HOMSEQ_METH_IDX:     first_state = HS_APPROACH;
			`HOMSEQ_METH_PRESS:   first_state = HS_PRESS;
			default:              first_state = HS_IDLE;
		endcase
	endfunction : first_state

	// Method captured once after reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			method        <= `HOMSEQ_METH_NONE;
			method_loaded <= 1'b0;
		end else if (!method_loaded) begin
			method        <= homing_method_sel; // R1
			method_loaded <= 1'b1;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			HS_IDLE:
				if (req_rise && mode_ok && method_loaded && !abs_encoder)
					next_state = first_state(method); // R16
			HS_MOVE:
				if (s_dec)
					next_state = HS_APPROACH; // R22
			HS_APPROACH:
				if ((method == `HOMSEQ_METH_DEC_IDX && index_pulse) ||
				    (method == `HOMSEQ_METH_DEC && s_dec) ||
				    (method == `HOMSEQ_METH_IDX && index_pulse))
					next_state = HS_CREEP; // R9
			HS_CREEP:
				next_state = HS_FINAL; // R10
			HS_FINAL:
				if (final_hit)
					next_state = HS_DONE; // R10
			HS_PRESS:
				if (det_exp)
					next_state = HS_HOLD; // R13
			HS_HOLD:
				if (hold_exp)
					next_state = HS_CREEP; // R14
			HS_DONE:
				next_state = HS_DONE;
			default:
				next_state = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state        <= HS_IDLE;
			resume_state <= HS_IDLE;
			halted       <= 1'b0;
			req_d        <= 1'b0;
			mode_d       <= 1'b0;
		end else begin
			req_d  <= s_req;
			mode_d <= s_mode;
			if (cancel) begin
				halted <= 1'b0; // R18
				state  <= HS_IDLE;
			end else if (halted) begin
				if (req_rise) begin
					halted <= 1'b0; // R17
					state  <= resume_state;
				end
			end else if (in_motion && req_fall) begin
				halted       <= 1'b1; // R16
				resume_state <= state;
			end else begin
				state <= next_state;
			end
		end
	end

	assign timer_start = (state == HS_IDLE) || (state == HS_PRESS && det_exp);

	homseq_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.clk     (clk),
		.resetn  (resetn),
		.start   (timer_start),
		.run     ((state == HS_PRESS || state == HS_HOLD) && !halted),
		.limit_ms(state == HS_HOLD ? press_hold_time : press_detect_time),
		.expired (hold_exp)
	); // R24
	assign det_exp = hold_exp;

	wire homseq_speed_t next_speed =
		(state == HS_MOVE)                          ? homing_move_speed :     // R7
		(state == HS_APPROACH || state == HS_PRESS) ? homing_approach_speed : // R8
		(state == HS_CREEP || state == HS_FINAL)    ? homing_creep_speed :    // R9
		28'h0;
	wire flip_final = pressing ? !dist_neg : dist_neg; // R11 R14
	wire next_rev = homing_direction_sel ^ ((state == HS_CREEP || state == HS_FINAL) && flip_final); // R3
	wire next_run = in_motion && !halted && state != HS_HOLD;
	wire next_err = method_unspecified_err || (req_rise && method == `HOMSEQ_METH_NONE && method_loaded); // R2
	wire next_ovs = press_overspeed_alarm ||
		(pressing && in_motion && motor_speed > press_overspeed_level); // R15
	wire homing_done = (state == HS_FINAL) && final_hit && !halted && !cancel && !req_fall;
	wire power_up_origin = !method_loaded && homing_method_sel == `HOMSEQ_METH_NONE; // R19
	wire homseq_pos_t load_val = abs_encoder ? abs_origin_value : origin_position_value; // R4 R6

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			motion_run             <= 1'b0;
			motion_reverse         <= 1'b0;
			speed_cmd              <= 28'h0;
			torque_limit_out       <= `HOMSEQ_TORQ_FULL;
			distance_start         <= 1'b0;
			distance_target        <= 32'sh0;
			position_load          <= 1'b0;
			position_load_value    <= 32'sh0;
			machine_position       <= 32'sh0;
			position_ready_out     <= 1'b0;
			method_unspecified_err <= 1'b0;
			press_overspeed_alarm  <= 1'b0;
		end else begin
			motion_run             <= next_run;
			motion_reverse         <= next_rev;
			speed_cmd              <= next_speed;
			torque_limit_out       <= (pressing && in_motion) ? press_torque_limit : `HOMSEQ_TORQ_FULL; // R12
			distance_start         <= (state == HS_CREEP) && !halted;
			distance_target        <= final_travel_distance; // R10
			position_load          <= homing_done || power_up_origin;
			position_load_value    <= power_up_origin ? encoder_position : load_val;
			machine_position       <= abs_encoder ? encoder_position + origin_position_value : encoder_position; // R5
			position_ready_out     <= position_ready_out || homing_done || power_up_origin; // R20
			method_unspecified_err <= next_err;
			press_overspeed_alarm  <= next_ovs;
		end
	end
	assign homing_halted = halted;

	a_err_on_none: assert property (@(posedge clk) disable iff (!resetn)
		(req_rise && method_loaded && method == `HOMSEQ_METH_NONE) |=> method_unspecified_err) // R2
		else $error("method error not raised");
	a_halt_stops: assert property (@(posedge clk) disable iff (!resetn)
		(in_motion && req_fall && !cancel && !halted) |=> ##1 !motion_run) // R16
		else $error("motion kept running after halt");
	a_resume_state: assert property (@(posedge clk) disable iff (!resetn)
		(halted && req_rise && !cancel) |=> state == $past(resume_state)) // R17
		else $error("resume lost its place");
	a_cancel_idle: assert property (@(posedge clk) disable iff (!resetn)
		cancel |=> state == HS_IDLE && !halted) // R18
		else $error("cancel did not return idle");
	a_ready_done: assert property (@(posedge clk) disable iff (!resetn)
		homing_done |=> position_ready_out && position_load) // R20
		else $error("ready not raised at completion");
	a_dec_approach: assert property (@(posedge clk) disable iff (!resetn)
		(state == HS_MOVE && s_dec && !halted && !req_fall && !cancel) |=> state == HS_APPROACH) // R22
		else $error("decel switch ignored");
	a_torque_press: assert property (@(posedge clk) disable iff (!resetn)
		(state == HS_PRESS) |=> torque_limit_out == $past(press_torque_limit)) // R12
		else $error("press torque not applied");
	a_move_speed: assert property (@(posedge clk) disable iff (!resetn)
		(state == HS_MOVE) |=> speed_cmd == $past(homing_move_speed)) // R7
		else $error("movement speed wrong");
	a_ovs_alarm: assert property (@(posedge clk) disable iff (!resetn)
		(pressing && in_motion && motor_speed > press_overspeed_level) |=> press_overspeed_alarm) // R15
		else $error("overspeed not flagged");
	a_load_value: assert property (@(posedge clk) disable iff (!resetn)
		(homing_done && !abs_encoder) |=> position_load_value == $past(origin_position_value)) // R4
		else $error("origin not loaded");

	c_done: cover property (@(posedge clk) disable iff (!resetn) homing_done);
	c_resume: cover property (@(posedge clk) disable iff (!resetn) halted && req_rise);
	c_cancel: cover property (@(posedge clk) disable iff (!resetn) cancel);
	c_press_hold: cover property (@(posedge clk) disable iff (!resetn) state == HS_HOLD && hold_exp);
endmodule : homseq_top

// ---- verif/homseq_motor_model.sv ----
`timescale 1ns/10ps
module homseq_motor_model
	import homseq_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// Motion command
	input  wire logic          motion_run,
	input  wire homseq_speed_t speed_cmd,
	input  wire logic          distance_start,
	input  wire logic          overspeed_en,
	// Feedback
	output homseq_speed_t      motor_speed,
	output homseq_pos_t        travelled,
	output logic               index_pulse
);
	logic [3:0] phase;
	// Overshoot on request, so the speed watch can trip
	assign motor_speed = motion_run ? speed_cmd + (overspeed_en ? 28'h0010000 : 28'h0000000) : 28'h0000000;
	assign index_pulse = motion_run && (phase == 4'hf);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			travelled <= 32'sh0;
			phase <= 4'h0;
		end else begin
			phase <= motion_run ? phase + 4'h1 : 4'h0;
			if (distance_start)
				travelled <= 32'sh0;
			else if (motion_run)
				travelled <= travelled + 32'sh1;
		end
	end
endmodule : homseq_motor_model

// ---- verif/tb_homseq_top.sv ----
`timescale 1ns/10ps
module tb_homseq_top;
	import homseq_pkg::*;
	logic clk = 0, resetn = 0, home_req = 0, jog_f = 0, jog_r = 0, mode_sel = 0, decel = 0, ovs_en = 0, dir = 0;
	logic abs_enc = 0;
	homseq_pos_t mpos;
	logic [2:0] meth = 0;
	logic [6:0] torq = 7'h28, torq_out;
	logic [13:0] t_det = 14'h2, t_hold = 14'h2;
	homseq_speed_t mspd, spd_cmd, s_move = 28'h00003e8, s_appr = 28'h0000050, s_creep = 28'h0000014;
	homseq_speed_t ovs_lvl = 28'h00007d0;
	homseq_pos_t trav, dist_tgt, ld_val, origin = 32'sh123, fin = 32'sh5, enc = 32'sh777;
	logic run, rev, dstart, pload, ready, halted, err, alarm, idx;
	int fail_count = 0, checks = 0;
	wire [7:0] flags = {~run, halted, alarm, err, ready, pload, dstart, run};
	always #25 clk = ~clk;
	homseq_top #(.TICK_CYCLES(10)) u_homseq_top (.clk(clk), .resetn(resetn), .home_req(home_req),
		.jog_forward_req(jog_f), .jog_reverse_req(jog_r), .mode_sel_in(mode_sel), .decel_switch_in(decel),
		.index_pulse(idx), .abs_encoder(abs_enc), .motor_speed(mspd), .encoder_position(enc), .travelled(trav),
		.torque_at_limit(1'b0), .homing_method_sel(meth), .homing_direction_sel(dir), .origin_position_value(origin),
		.abs_origin_value(32'sh0), .homing_move_speed(s_move), .homing_approach_speed(s_appr),
		.homing_creep_speed(s_creep), .final_travel_distance(fin), .press_torque_limit(torq),
		.press_detect_time(t_det), .press_hold_time(t_hold), .press_overspeed_level(ovs_lvl), .motion_run(run),
		.motion_reverse(rev), .speed_cmd(spd_cmd), .torque_limit_out(torq_out), .distance_start(dstart),
		.distance_target(dist_tgt), .position_load(pload), .position_load_value(ld_val), .machine_position(mpos),
		.position_ready_out(ready), .homing_halted(halted), .method_unspecified_err(err),
		.press_overspeed_alarm(alarm));
	homseq_motor_model u_homseq_motor_model (.clk(clk), .resetn(resetn), .motion_run(run), .speed_cmd(spd_cmd),
		.distance_start(dstart), .overspeed_en(ovs_en), .motor_speed(mspd), .travelled(trav), .index_pulse(idx));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_flag(input int b, input int n);
		int cnt;
		cnt = 0;
		while (flags[b] !== 1'b1) begin
			if (cnt == n) begin
				fail_count++;
				$display("[ERR] %0t got %h exp %h", $time, flags, 8'h1 << b);
				give_verdict();
			end
			step(1);
			cnt++;
		end
	endtask : wait_flag
	task automatic do_reset(input logic [2:0] m);
		resetn = 0;
		home_req = 0;
		decel = 0;
		meth = m;
		step(12);
		resetn = 1;
	endtask : do_reset
	task automatic t_method0;
		do_reset(3'h0);
		wait_flag(2, 10);
		chk(ld_val, enc);
		step(1);
		chk(ready, 1'b1);
		home_req = 1;
		wait_flag(4, 10);
		chk(run, 1'b0);
		$display("method 0 done");
	endtask : t_method0
	task automatic t_method2;
		do_reset(3'h2);
		dir = 1;
		home_req = 1;
		wait_flag(0, 10);
		chk(rev, 1'b1);
		chk(spd_cmd, s_appr);
		decel = 1;
		wait_flag(1, 10);
		chk(dist_tgt, fin);
		step(1);
		chk(spd_cmd, s_creep);
		wait_flag(2, 40);
		chk(ld_val, origin);
		step(1);
		chk(ready, 1'b1);
		dir = 0;
		$display("method 2 done");
	endtask : t_method2
	task automatic t_method1;
		do_reset(3'h1);
		fin = -32'sh4;
		home_req = 1;
		wait_flag(0, 10);
		chk(spd_cmd, s_move);
		chk(rev, 1'b0);
		decel = 1;
		step(4);
		chk(spd_cmd, s_appr);
		wait_flag(1, 40);
		step(1);
		chk(rev, 1'b1);
		wait_flag(2, 40);
		chk(ld_val, origin);
		fin = 32'sh5;
		$display("method 1 done");
	endtask : t_method1
	task automatic t_halt;
		do_reset(3'h2);
		home_req = 1;
		wait_flag(0, 10);
		decel = 1;
		wait_flag(1, 10);
		home_req = 0;
		decel = 0;
		wait_flag(7, 10);
		chk(halted, 1'b1);
		home_req = 1;
		wait_flag(0, 10);
		chk(spd_cmd, s_creep);
		do_reset(3'h2);
		home_req = 1;
		wait_flag(0, 10);
		home_req = 0;
		wait_flag(6, 10);
		jog_r = 1;
		step(4);
		jog_r = 0;
		chk(halted, 1'b0);
		home_req = 1;
		wait_flag(0, 10);
		chk(spd_cmd, s_appr);
		$display("halt done");
	endtask : t_halt
	task automatic t_press;
		do_reset(3'h4);
		home_req = 1;
		wait_flag(0, 10);
		chk(torq_out, torq);
		wait_flag(7, 60);
		chk(alarm, 1'b0);
		wait_flag(2, 120);
		chk(ld_val, origin);
		do_reset(3'h4);
		ovs_en = 1;
		home_req = 1;
		wait_flag(5, 20);
		chk(alarm, 1'b1);
		ovs_en = 0;
		$display("press done");
	endtask : t_press
	task automatic t_abs;
		do_reset(3'h2);
		abs_enc = 1;
		step(3);
		chk(mpos, enc + origin);
		home_req = 1;
		step(6);
		chk(run, 1'b0);
		abs_enc = 0;
		$display("absolute encoder done");
	endtask : t_abs
	initial begin
		t_method0();
		t_method2();
		t_method1();
		t_halt();
		t_press();
		t_abs();
		give_verdict();
	end
endmodule : tb_homseq_top
